// ---- wtc_timer.v ----
// wtc_timer: 16-bit timer/counter with axi4-lite registers and overflow interrupt
// assumes all inputs synchronous to REF_CLK; one write and one read at a time
//
// Function
// - counter is two readable writable byte registers
// - counts 0000h to FFFFh then wraps
// - overflow sets sticky flag bit 0
// - enable bit 0 gates the interrupt
// - timer oscillator may clock system
// - status bit set while clock select 01 and timer oscillator active
// - status bit tracks actual clock source
// - source select: instruction cycle or external edges
// - counts only while counter_on set
// - two-bit prescaler 1, 2, 4, 8
// - special event trigger clears counter
`timescale 1ns/1ps
`include "wtc_map.vh"

module wtc_timer (
    // clock and reset
    input wire REF_CLK,
    input wire ARST_N,
    // axi4-lite write address
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    // axi4-lite write data
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    // axi4-lite write response
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // axi4-lite read address
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    // axi4-lite read data
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // counter inputs
    input wire EXT_CLK_IN,
    input wire SPECIAL_EVENT_RESET,
    // system clock status from the clock unit
    input wire [1:0] SYSTEM_CLOCK_SELECT,
    input wire SECONDARY_OSC_ACTIVE,
    // outputs
    output wire SECONDARY_OSC_ENABLE,
    output wire IRQ
);

    localparam ST_IDLE = 3'b001;
    localparam ST_RESP = 3'b010;
    localparam ST_WAIT = 3'b100;

    // word address decode, shared by read and write paths
    function [2:0] reg_index;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'b00})
                `WTC_OFF_LOW: reg_index = 3'd0;
                `WTC_OFF_HIGH: reg_index = 3'd1;
                `WTC_OFF_CTRL: reg_index = 3'd2;
                `WTC_OFF_FLAG: reg_index = 3'd3;
                `WTC_OFF_ENABLE: reg_index = 3'd4;
                `WTC_OFF_CLKSEL: reg_index = 3'd5;
                default: reg_index = 3'd7;
            endcase
        end
    endfunction

    reg [15:0] wide_counter_r;
    reg [15:0] wide_counter_nxt;
    reg [5:0] ctrl_r;
    reg [5:0] ctrl_nxt;
    reg wide_overflow_flag_r;
    reg wide_overflow_flag_nxt;
    reg wide_overflow_enable_r;
    reg wide_overflow_enable_nxt;
    reg [1:0] instr_div_r;
    reg ext_prev_r;
    reg [2:0] wr_state_r;
    reg [2:0] wr_state_nxt;
    reg aw_held_r;
    reg w_held_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;

    wire counter_on = ctrl_r[`WTC_CTRL_ON];
    wire counter_source_select = ctrl_r[`WTC_CTRL_SRC];
    wire [1:0] input_prescale_select = ctrl_r[`WTC_CTRL_PS_HI:`WTC_CTRL_PS_LO];
    wire instr_tick = (instr_div_r == (`WTC_INSTR_CLKS - 1));
    wire ext_rise = EXT_CLK_IN && !ext_prev_r;
    wire raw_tick = counter_on && (counter_source_select ? ext_rise : instr_tick);
    wire count_tick;
    // status follows live clock-unit state, so a failed oscillator shows at once
    wire secondary_clock_status = (SYSTEM_CLOCK_SELECT == `WTC_SCS_TIMER_OSC)
        && SECONDARY_OSC_ACTIVE;

    // prescaler restarts when the counter is written, as a fresh count expects
    wire cnt_write;

    wtc_prescaler u_prescaler (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .clear(cnt_write || !counter_on),
        .ratio_sel(input_prescale_select),
        .tick_in(raw_tick),
        .tick_out(count_tick)
    );

    assign SECONDARY_OSC_ENABLE = ctrl_r[`WTC_CTRL_OSCEN];
    assign IRQ = wide_overflow_flag_r && wide_overflow_enable_r;

    // write channel: take address and data in either order, then answer
    wire aw_have = aw_held_r || S_AXI_AWVALID;
    wire w_have = w_held_r || S_AXI_WVALID;
    wire [7:0] wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
    wire [31:0] wr_data = w_held_r ? w_data_r : S_AXI_WDATA;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB;
    wire wr_fire = (wr_state_r == ST_IDLE) && aw_have && w_have;
    wire [2:0] wr_idx = reg_index(wr_addr);
    wire wr_lane0 = wr_fire && wr_strb[0];

    assign S_AXI_AWREADY = (wr_state_r == ST_IDLE) && !aw_held_r;
    assign S_AXI_WREADY = (wr_state_r == ST_IDLE) && !w_held_r;
    assign cnt_write = wr_lane0 && (wr_idx == 3'd0 || wr_idx == 3'd1);

    always @* begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            ST_IDLE: begin
                if (wr_fire) begin
                    wr_state_nxt = ST_RESP;
                end
            end
            ST_RESP: begin
                if (S_AXI_BREADY) begin
                    wr_state_nxt = ST_IDLE;
                end
            end
            default: wr_state_nxt = ST_IDLE;
        endcase
    end

    // counter next value: write beats special event reset beats counting
    always @* begin
        wide_counter_nxt = wide_counter_r;
        if (SPECIAL_EVENT_RESET) begin
            wide_counter_nxt = `WTC_CNT_RST;
        end else if (count_tick) begin
            wide_counter_nxt = wide_counter_r + 16'h0001;
        end
        if (wr_lane0 && wr_idx == 3'd0) begin
            wide_counter_nxt[7:0] = wr_data[7:0];
        end
        if (wr_lane0 && wr_idx == 3'd1) begin
            wide_counter_nxt[15:8] = wr_data[7:0];
        end
    end

    always @* begin
        ctrl_nxt = ctrl_r;
        wide_overflow_enable_nxt = wide_overflow_enable_r;
        wide_overflow_flag_nxt = wide_overflow_flag_r;
        if (wr_lane0 && wr_idx == 3'd2) begin
            ctrl_nxt = wr_data[5:0];
        end
        if (wr_lane0 && wr_idx == 3'd4) begin
            wide_overflow_enable_nxt = wr_data[`WTC_FLAG_OVF];
        end
        if (wr_lane0 && wr_idx == 3'd3 && wr_data[`WTC_FLAG_OVF]) begin
            wide_overflow_flag_nxt = 1'b0;
        end
        // set wins over a same-cycle clear
        if (count_tick && !SPECIAL_EVENT_RESET && wide_counter_r == 16'hffff) begin
            wide_overflow_flag_nxt = 1'b1;
        end
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wide_counter_r <= `WTC_CNT_RST;
            ctrl_r <= `WTC_CTRL_RST;
            wide_overflow_flag_r <= 1'b0;
            wide_overflow_enable_r <= 1'b0;
            instr_div_r <= 2'h0;
            ext_prev_r <= 1'b0;
            wr_state_r <= ST_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end else begin
            wide_counter_r <= wide_counter_nxt;
            ctrl_r <= ctrl_nxt;
            wide_overflow_flag_r <= wide_overflow_flag_nxt;
            wide_overflow_enable_r <= wide_overflow_enable_nxt;
            instr_div_r <= instr_tick ? 2'h0 : instr_div_r + 2'h1;
            ext_prev_r <= EXT_CLK_IN;
            wr_state_r <= wr_state_nxt;
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (wr_idx == 3'd7 || wr_idx == 3'd5) ? 2'h2 : 2'h0;
            end else begin
                if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                    aw_held_r <= 1'b1;
                    aw_addr_r <= S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && S_AXI_WREADY) begin
                    w_held_r <= 1'b1;
                    w_data_r <= S_AXI_WDATA;
                    w_strb_r <= S_AXI_WSTRB;
                end
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
        end
    end

    // read channel: one outstanding read, data registered
    reg [31:0] rd_word;
    wire [2:0] rd_idx = reg_index(S_AXI_ARADDR);
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always @* begin
        rd_word = 32'h0000_0000;
        case (rd_idx)
            3'd0: rd_word[7:0] = wide_counter_r[7:0];
            3'd1: rd_word[7:0] = wide_counter_r[15:8];
            3'd2: rd_word[7:0] = {1'b0, secondary_clock_status, ctrl_r};
            3'd3: rd_word[0] = wide_overflow_flag_r;
            3'd4: rd_word[0] = wide_overflow_enable_r;
            3'd5: rd_word[1:0] = SYSTEM_CLOCK_SELECT;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'h0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= (rd_idx == 3'd7) ? 2'h2 : 2'h0;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

endmodule // wtc_timer

// ---- wtc_map.vh ----
// register map, field positions, reset values and timing counts of the wide timer
// assumes a 32-bit axi4-lite register bus, one aligned word per register
`ifndef WTC_MAP_VH
`define WTC_MAP_VH

// byte offsets
`define WTC_OFF_LOW 8'h00
`define WTC_OFF_HIGH 8'h04
`define WTC_OFF_CTRL 8'h08
`define WTC_OFF_FLAG 8'h0c
`define WTC_OFF_ENABLE 8'h10
`define WTC_OFF_CLKSEL 8'h14

// control register fields
`define WTC_CTRL_ON 0
`define WTC_CTRL_SRC 1
`define WTC_CTRL_SYNC 2
`define WTC_CTRL_OSCEN 3
`define WTC_CTRL_PS_LO 4
`define WTC_CTRL_PS_HI 5
`define WTC_CTRL_RUN 6

// flag and enable registers
`define WTC_FLAG_OVF 0

// clock select field: 01 means the timer oscillator drives the system clock
`define WTC_SCS_TIMER_OSC 2'h1

// reset values
`define WTC_CTRL_RST 6'h00
`define WTC_CNT_RST 16'h0000

// timing: system clock period and instruction cycle length
`define WTC_CLK_PERIOD_NS 100
`define WTC_INSTR_CYCLE_NS 400
`define WTC_INSTR_CLKS (`WTC_INSTR_CYCLE_NS / `WTC_CLK_PERIOD_NS)

`endif

// ---- wtc_prescaler.v ----
// wtc_prescaler: divides count ticks by 1, 2, 4 or 8 ahead of the wide counter
// assumes tick_in is a one-cycle pulse on the system clock
`timescale 1ns/1ps

module wtc_prescaler (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // control
    input wire clear,
    input wire [1:0] ratio_sel,
    input wire tick_in,
    // output
    output reg tick_out
);

    reg [2:0] div_r;
    reg [2:0] div_nxt;
    reg [2:0] top;

    always @* begin
        case (ratio_sel)
            2'h0: top = 3'h0;
            2'h1: top = 3'h1;
            2'h2: top = 3'h3;
            default: top = 3'h7;
        endcase
    end

    always @* begin
        div_nxt = div_r;
        if (clear) begin
            div_nxt = 3'h0;
        end else if (tick_in) begin
            div_nxt = (div_r >= top) ? 3'h0 : div_r + 3'h1;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 3'h0;
            tick_out <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_out <= tick_in && !clear && (div_r >= top);
        end
    end

endmodule // wtc_prescaler

// ---- wtc_timer_asserts.sv ----
// wtc_timer_asserts: port checks on the wide timer, bound below
// assumes a write offers address and data together
`timescale 1ns/1ps
`include "wtc_map.vh"
module wtc_timer_asserts (
    // clock and reset
    input logic REF_CLK, ARST_N,
    // register bus
    input logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR,
    input logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic S_AXI_RVALID, S_AXI_RREADY,
    // clock unit
    input logic [1:0] SYSTEM_CLOCK_SELECT,
    input logic SECONDARY_OSC_ACTIVE, SECONDARY_OSC_ENABLE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    wire wt = S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY;
    wire rt = S_AXI_ARVALID & S_AXI_ARREADY;
    // timer oscillator really clocks the system: select field 01 and oscillator alive
    wire osc_drives = (SYSTEM_CLOCK_SELECT == `WTC_SCS_TIMER_OSC) && SECONDARY_OSC_ACTIVE;
    wire ctrl_wt = wt && (S_AXI_AWADDR == `WTC_OFF_CTRL);
    a_write_answer: assert property (wt |=> S_AXI_BVALID) else $error("no write answer");
    a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
    a_read_answer: assert property (rt |=> S_AXI_RVALID) else $error("no read answer");
    a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
    a_byte_wide: assert property (rt |=> S_AXI_RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    a_status_live: assert property (rt && S_AXI_ARADDR == `WTC_OFF_CTRL |=>
        S_AXI_RDATA[7:6] == {1'b0, $past(osc_drives)}) else $error("clock status wrong");
    a_clksel_ro: assert property (wt && S_AXI_AWADDR == `WTC_OFF_CLKSEL |=>
        S_AXI_BRESP == 2'h2) else $error("select mirror written");
    a_osc_by_write: assert property ($changed(SECONDARY_OSC_ENABLE) |->
        $past(ctrl_wt)) else $error("osc enable moved");
endmodule // wtc_timer_asserts

bind wtc_timer wtc_timer_asserts u_chk (.*);

// ---- wtc_ext_src.sv ----
// wtc_ext_src: external count clock and timer oscillator model
// assumes run changes just after a rising clk edge
`timescale 1ns/1ps
module wtc_ext_src (
    // bench side
    input logic clk, run, fail,
    // timer side
    input logic osc_en,
    output logic ext_clk, osc_active,
    output int edges
);
    logic [2:0] ph;
    initial begin
        ph = 3'h0;
        ext_clk = 1'b0;
        edges = 0;
    end
    // a failed oscillator no longer runs
    assign osc_active = osc_en & ~fail;
    // line rests low between runs
    always @(posedge clk) begin
        ph <= run ? ph + 3'h1 : 3'h0;
        ext_clk <= run & ~ph[2];
        if (run & ~ph[2] & ~ext_clk) edges <= edges + 1;
    end
endmodule // wtc_ext_src

// ---- tb.sv ----
// tb: self-checking bench for wtc_timer over axi4-lite
// assumes wtc_ext_src plays count clock and oscillator
`timescale 1ns/1ps
`include "wtc_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic sev = 0, run = 0, fl = 0, ta, tw, dn;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rdata, d;
    logic [1:0] system_clock_select = 2'h0, bresp, rresp, r;
    logic awr, wrd, bv, arr, rv, ext, act, oen, irq;
    int edges, n, i, err_total = 0, tests_run = 0;
    wtc_timer dut (.REF_CLK(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .EXT_CLK_IN(ext),
        .SPECIAL_EVENT_RESET(sev), .SYSTEM_CLOCK_SELECT(system_clock_select), .SECONDARY_OSC_ACTIVE(act),
        .SECONDARY_OSC_ENABLE(oen), .IRQ(irq));
    wtc_ext_src u_src (.clk(clk), .run(run), .fail(fl), .osc_en(oen), .ext_clk(ext),
        .osc_active(act), .edges(edges));
    initial forever #50 clk = ~clk;
    task final_report;
        $display("%0d checks %0d bad", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task to_err;
        err_total++;
        $display("unexpected %0t timeout", $time);
        final_report;
    endtask
    // ready comes a cycle late so a stalled answer gets held
    task wr(input [7:0] a, input [31:0] x, input [1:0] e = 2'h0);
        awa <= a; wd <= x; awv <= 1; wv <= 1; dn = 0;
        for (n = 0; !dn; n++) begin
            if (n > 50) to_err;
            @(negedge clk); ta = awv & awr; tw = wv & wrd; dn = bv === 1'b1;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        `CHK(bresp, e)
        bry <= 1;
        @(posedge clk) bry <= 0;
    endtask
    task rd(input [7:0] a);
        ara <= a; arv <= 1; dn = 0;
        for (n = 0; !dn; n++) begin
            if (n > 50) to_err;
            @(negedge clk); ta = arv & arr; dn = rv === 1'b1;
            @(posedge clk);
            if (ta) arv <= 0;
        end
        d = rdata; r = rresp; rry <= 1;
        @(posedge clk) rry <= 0;
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        rd(a);
        `CHK(d, e)
    endtask
    task t_regs;
        for (i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0);
        wr(`WTC_OFF_LOW, 32'h5a);
        wr(`WTC_OFF_HIGH, 32'ha5);
        rchk(`WTC_OFF_LOW, 32'h5a);
        rchk(`WTC_OFF_HIGH, 32'ha5);
        wr(`WTC_OFF_CTRL, 32'hfe);
        rchk(`WTC_OFF_CTRL, 32'h3e);
        `CHK(oen, 1'b1)
        wr(`WTC_OFF_CTRL, 32'h0);
        wr(`WTC_OFF_CLKSEL, 32'h0, 2'h2);
        rd(8'h18);
        `CHK({r, d}, 34'h2_0000_0000)
        $display("t_regs done");
    endtask
    task t_wrap;
        wr(`WTC_OFF_ENABLE, 32'h1);
        wr(`WTC_OFF_HIGH, 32'hff);
        wr(`WTC_OFF_LOW, 32'hf0);
        wr(`WTC_OFF_CTRL, 32'h1);
        for (n = 0; irq !== 1'b1; n++) begin
            if (n > 300) to_err;
            @(posedge clk);
        end
        `CHK(n >= 56 && n <= 72, 1'b1)
        wr(`WTC_OFF_CTRL, 32'h0);
        rchk(`WTC_OFF_HIGH, 32'h0);
        wr(`WTC_OFF_FLAG, 32'h0);
        rchk(`WTC_OFF_FLAG, 32'h1);
        wr(`WTC_OFF_ENABLE, 32'h0);
        `CHK(irq, 1'b0)
        wr(`WTC_OFF_ENABLE, 32'h1);
        `CHK(irq, 1'b1)
        wr(`WTC_OFF_FLAG, 32'h1);
        `CHK(irq, 1'b0)
        $display("t_wrap done");
    endtask
    task t_scale;
        for (i = 0; i < 4; i++) begin
            wr(`WTC_OFF_LOW, 32'h0);
            wr(`WTC_OFF_CTRL, 32'h1 | i << 4);
            repeat (256) @(posedge clk);
            wr(`WTC_OFF_CTRL, 32'h0);
            rd(`WTC_OFF_LOW);
            `CHK(d >= (64 >> i) - 1 && d <= (64 >> i) + 1, 1'b1)
            repeat (20) @(posedge clk);
            rchk(`WTC_OFF_LOW, d);
        end
        $display("t_scale done");
    endtask
    task t_ext;
        wr(`WTC_OFF_LOW, 32'h0);
        wr(`WTC_OFF_CTRL, 32'h3);
        run <= 1;
        repeat (80) @(posedge clk);
        run <= 0;
        repeat (10) @(posedge clk);
        rchk(`WTC_OFF_LOW, edges);
        wr(`WTC_OFF_CTRL, 32'h0);
        $display("t_ext done");
    endtask
    task t_spec;
        wr(`WTC_OFF_LOW, 32'h33);
        sev <= 1;
        @(posedge clk) sev <= 0;
        rchk(`WTC_OFF_LOW, 32'h0);
        $display("t_spec done");
    endtask
    task t_stat;
        wr(`WTC_OFF_CTRL, 32'h8);
        for (i = 0; i < 8; i++) begin
            system_clock_select <= i[1:0];
            fl <= i[2];
            @(posedge clk);
            rchk(`WTC_OFF_CTRL, i[2:0] == 3'h1 ? 32'h48 : 32'h8);
        end
        system_clock_select <= 2'h1;
        fl <= 0;
        wr(`WTC_OFF_CTRL, 32'h0);
        `CHK(oen, 1'b0)
        rchk(`WTC_OFF_CTRL, 32'h0);
        $display("t_stat done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_regs;
        t_wrap;
        t_scale;
        t_ext;
        t_spec;
        t_stat;
        final_report;
    end
endmodule // tb
